// file: common/jtb_pkg.sv
// Package: constants, types and helpers of the boundary-scan test access port.
//
// Function
// - Five TMS-high TCK edges reach Test-Logic-Reset.
// - No power-up reset; tester must reset TAP.
// - State changes on rising TCK by TMS.
// - Test-Logic-Reset leaves test logic inactive.
// - Select-DR-Scan branches by TMS to DR/IR.
// - Capture-IR loads fixed pattern ending 01.
// - Shift-IR shifts TDI in, bits to TDO.
// - Exit1 picks Pause/Update; Pause holds contents.
// - Update-IR latches instruction on falling TCK.
// - Capture-DR loads the selected data register.
// - DR path states mirror the IR path.
// - Instruction register 4 bits, LSB nearest TDO.
// - Bypass, boundary, ID registers in parallel.
// - Bypass stage cleared in Capture-DR.
// - Bypass shifting leaves device function undisturbed.
// - Boundary register loads/reads pin cells serially.
// - Codes 0,1 boundary; 2 ID; 4 high-Z; F bypass.
// - ID register 32 bits: version, part, maker, 1.
// - High-Z instruction floats outputs, selects bypass.

package jtb_pkg;

    // -------------------------------------------------------------------
    // Instruction register
    // -------------------------------------------------------------------
    localparam int         IR_W       = 4;       // Instruction width.
    localparam logic [3:0] INS_EXTEST = 4'h0;    // Boundary register, pins driven.
    localparam logic [3:0] INS_SAMPLE = 4'h1;    // Boundary register, device normal.
    localparam logic [3:0] INS_IDCODE = 4'h2;    // Identification register.
    localparam logic [3:0] INS_HIGHZ  = 4'h4;    // Outputs floated, bypass path.
    localparam logic [3:0] INS_BYPASS = 4'hF;    // Bypass register.
    localparam logic [3:0] IR_CAPTURE = 4'h1;    // Captured pattern, low bits 01.
    localparam logic [3:0] IR_RESET   = INS_IDCODE; // Instruction after reset.

    // -------------------------------------------------------------------
    // Identification register (values arbitrary, not a real part)
    // -------------------------------------------------------------------
    localparam logic [3:0]  ID_VERSION = 4'h1;     // Arbitrary version.
    localparam logic [15:0] ID_PART    = 16'h5A5A; // Arbitrary part number.
    localparam logic [10:0] ID_MAKER   = 11'h2A5;  // Arbitrary maker code.
    localparam logic [31:0] IDCODE_VAL = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // -------------------------------------------------------------------
    // Boundary register and pins
    // -------------------------------------------------------------------
    localparam int PIN_W = 4;   // Functional input and output pins each.
    localparam int BSR_W = 9;   // Cells: inputs, outputs, output enable.

    // Boundary cells; the input cells sit nearest TDO.
    typedef struct packed {
        logic             oe;   // Output enable cell.
        logic [PIN_W-1:0] outp; // Output pin cells.
        logic [PIN_W-1:0] inp;  // Input pin cells.
    } jtb_bsr_s;

    // -------------------------------------------------------------------
    // Controller states and data register selection
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtb_state_e;

    typedef enum logic [1:0] {DS_BYPASS, DS_BSR, DS_ID} jtb_dsel_e;

    // Next controller state from the TMS level sampled on the rising edge.
    function automatic jtb_state_e tap_next(input jtb_state_e s, input logic tms);
        unique case (s)
            ST_TLR:      tap_next = tms ? ST_TLR     : ST_RTI;
            ST_RTI:      tap_next = tms ? ST_SEL_DR  : ST_RTI;
            ST_SEL_DR:   tap_next = tms ? ST_SEL_IR  : ST_CAP_DR;
            ST_CAP_DR:   tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: tap_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: tap_next = tms ? ST_UPD_DR  : ST_PAUSE_DR;
            ST_PAUSE_DR: tap_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: tap_next = tms ? ST_UPD_DR  : ST_SHIFT_DR;
            ST_UPD_DR:   tap_next = tms ? ST_SEL_DR  : ST_RTI;
            ST_SEL_IR:   tap_next = tms ? ST_TLR     : ST_CAP_IR;
            ST_CAP_IR:   tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: tap_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: tap_next = tms ? ST_UPD_IR  : ST_PAUSE_IR;
            ST_PAUSE_IR: tap_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: tap_next = tms ? ST_UPD_IR  : ST_SHIFT_IR;
            ST_UPD_IR:   tap_next = tms ? ST_SEL_DR  : ST_RTI;
        endcase
    endfunction

    // Data register in the serial path for an instruction.
    function automatic jtb_dsel_e dr_select(input logic [3:0] ir);
        if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
            dr_select = DS_BSR;
        end else if (ir == INS_IDCODE) begin
            dr_select = DS_ID;
        end else begin
            dr_select = DS_BYPASS;
        end
    endfunction

    // -------------------------------------------------------------------
    // Module state records
    // -------------------------------------------------------------------
    typedef struct packed {
        jtb_state_e        state;    // Controller state.
        logic [IR_W-1:0]   ir_shift; // Instruction shift stages.
        logic              byp;      // Bypass stage.
        logic [31:0]       id_shift; // Identification shift path.
        jtb_bsr_s          bsr;      // Boundary shift cells.
    } jtb_rise_s;

    typedef struct packed {
        logic [IR_W-1:0]   ir_act;   // Active instruction latch.
        jtb_bsr_s          bsr_upd;  // Boundary update latches.
        logic              upd_tgl;  // Flips on each boundary update.
        logic              extest;   // Pins driven from boundary cells.
        logic              highz;    // All outputs floated.
        logic              in_tlr;   // Controller in Test-Logic-Reset.
        logic              tdo;      // Serial output bit.
        logic              tdo_oe;   // Serial output driven.
    } jtb_fall_s;

    typedef struct packed {
        logic              tgl_seen; // Last update toggle taken.
        jtb_bsr_s          bsr;      // Boundary word in this domain.
        logic [PIN_W-1:0]  pad_out;  // Output pin levels.
        logic              pad_oe;   // Output pin enable.
        logic [PIN_W-1:0]  core_in;  // Levels offered to the core.
        logic              idle;     // Test logic in reset.
    } jtb_sys_s;

endpackage : jtb_pkg

// file: src/jtb_sync.sv
// Two flip-flop level synchroniser for a bundle of independent bits.
`timescale 1ns/1ns
`default_nettype none

module jtb_sync #(
    parameter int W = 1                       // Number of bits.
) (
    input  wire logic         clk_in,         // Destination clock.
    input  wire logic         rst_n_in,       // Asynchronous reset, active low.
    input  wire logic [W-1:0] d_in,           // Bits from another domain.
    output logic      [W-1:0] q_out           // Bits safe for this domain.
);

    // -------------------------------------------------------------------
    // State: first stage is read only by the second.
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;                     // Metastable catch stage.
        logic [W-1:0] s2;                     // Settled stage.
    } jtb_sync_s;

    jtb_sync_s st_reg;                        // Registered state.
    jtb_sync_s st_next;                       // Next state.

    // Shift the bundle one stage per edge.
    always_comb begin
        st_next.s1 = d_in;
        st_next.s2 = st_reg.s1;
    end

    // Register the stages; reset to zero.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.s2;

endmodule // jtb_sync

`default_nettype wire

// file: src/jtb_tap.sv
// Boundary-scan test access port with pin boundary cells of a queue device.
`timescale 1ns/1ns
`default_nettype none

module jtb_tap
    import jtb_pkg::*;
(
    input  wire logic             CLK_IN,        // Device clock, 10 MHz.
    input  wire logic             RST_N_IN,      // Device reset, active low.
    input  wire logic             TCK_IN,        // Test clock.
    input  wire logic             TRST_N_IN,     // Test reset, active low.
    input  wire logic             TMS_IN,        // Test mode select.
    input  wire logic             TDI_IN,        // Test serial input.
    output logic                  TDO_OUT,       // Test serial output.
    output logic                  TDO_OE_OUT,    // Serial output enable.
    input  wire logic [PIN_W-1:0] PAD_IN,        // Functional input pins.
    output logic      [PIN_W-1:0] PAD_OUT,       // Functional output pins.
    output logic                  PAD_OE_OUT,    // Output pin enable.
    input  wire logic [PIN_W-1:0] CORE_DATA_IN,  // Core output levels.
    input  wire logic             CORE_OE_IN,    // Core output enable.
    output logic      [PIN_W-1:0] CORE_IN_OUT,   // Input levels to the core.
    output logic                  TEST_IDLE_OUT  // Test logic in reset.
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    jtb_rise_s        rise_reg;   // Rising-edge TCK state.
    jtb_rise_s        rise_next;  // Its next value.
    jtb_fall_s        fall_reg;   // Falling-edge TCK state.
    jtb_fall_s        fall_next;  // Its next value.
    jtb_sys_s         sys_reg;    // Device clock state.
    jtb_sys_s         sys_next;   // Its next value.
    jtb_dsel_e        dsel;       // Data register in the path.
    jtb_bsr_s         bsr_cap;    // Values captured into boundary cells.
    logic [BSR_W-1:0] tck_seen;   // Pin and core levels on TCK.
    logic [3:0]       sys_flags;  // Test flags on the device clock.
    logic [PIN_W-1:0] pad_sys;    // Input pins on the device clock.
    logic             s_tgl;      // Update toggle, settled.
    logic             s_ext;      // External test active, settled.
    logic             s_hz;       // High-impedance active, settled.
    logic             s_tlr;      // Reset state, settled.

    // The active instruction picks one of three parallel paths.
    assign dsel = dr_select(fall_reg.ir_act);

    // -------------------------------------------------------------------
    // Crossings
    // -------------------------------------------------------------------

    // Pins and core levels are sampled into the test clock domain.
    jtb_sync #(.W(BSR_W)) u_sync_tck (
        .clk_in   (TCK_IN),
        .rst_n_in (TRST_N_IN),
        .d_in     ({CORE_OE_IN, CORE_DATA_IN, PAD_IN}),
        .q_out    (tck_seen)
    );

    // Test mode levels and the update toggle move to the device clock.
    jtb_sync #(.W(4)) u_sync_flags (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({fall_reg.in_tlr, fall_reg.highz, fall_reg.extest,
                    fall_reg.upd_tgl}),
        .q_out    (sys_flags)
    );

    // Input pins are also sampled on the device clock for the core.
    jtb_sync #(.W(PIN_W)) u_sync_pad (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .d_in     (PAD_IN),
        .q_out    (pad_sys)
    );

    assign s_tgl = sys_flags[0];
    assign s_ext = sys_flags[1];
    assign s_hz  = sys_flags[2];
    assign s_tlr = sys_flags[3];
    assign bsr_cap = jtb_bsr_s'(tck_seen);

    // -------------------------------------------------------------------
    // Rising TCK edge: controller and shift stages
    // -------------------------------------------------------------------

    // Every change happens here, chosen by the sampled TMS level. Stages
    // hold in every state that neither captures nor shifts, which gives
    // the pause states their hold.
    always_comb begin
        rise_next = rise_reg;
        rise_next.state = tap_next(rise_reg.state, TMS_IN);
        if (rise_reg.state == ST_CAP_IR) begin
            // Fixed pattern; lowest two bits read 01.
            rise_next.ir_shift = IR_CAPTURE;
        end else if (rise_reg.state == ST_SHIFT_IR) begin
            // LSB leaves towards TDO, TDI enters at the top.
            rise_next.ir_shift = {TDI_IN, rise_reg.ir_shift[IR_W-1:1]};
        end else if (rise_reg.state == ST_CAP_DR) begin
            // Only the selected register loads.
            unique case (dsel)
                DS_BYPASS: rise_next.byp = 1'b0;
                DS_ID:     rise_next.id_shift = IDCODE_VAL;
                DS_BSR:    rise_next.bsr = bsr_cap;
            endcase
        end else if (rise_reg.state == ST_SHIFT_DR) begin
            unique case (dsel)
                DS_BYPASS: rise_next.byp = TDI_IN;
                DS_ID:     rise_next.id_shift = {TDI_IN, rise_reg.id_shift[31:1]};
                DS_BSR: begin
                    rise_next.bsr = jtb_bsr_s'({TDI_IN, rise_reg.bsr[BSR_W-1:1]});
                end
            endcase
        end
    end

    // TRST low forces the reset state at once; without it the controller
    // waits for the tester, as there is no power-up reset of its own.
    always_ff @(posedge TCK_IN or negedge TRST_N_IN) begin
        if (!TRST_N_IN) begin
            rise_reg       <= '0;
            rise_reg.state <= ST_TLR;
        end else begin
            rise_reg <= rise_next;
        end
    end

    // -------------------------------------------------------------------
    // Falling TCK edge: latches, mode flags and serial output
    // -------------------------------------------------------------------

    // Latches change half a cycle after the rising edge, so the tester's
    // serial data and the pins never see a half-updated value.
    always_comb begin
        fall_next = fall_reg;
        if (rise_reg.state == ST_TLR) begin
            // Test logic idle; the identification path is ready at once.
            fall_next.ir_act = IR_RESET;
        end else if (rise_reg.state == ST_UPD_IR) begin
            fall_next.ir_act = rise_reg.ir_shift;
        end
        if (rise_reg.state == ST_UPD_DR && dsel == DS_BSR) begin
            // Preload or external test data goes to the update cells.
            fall_next.bsr_upd = rise_reg.bsr;
            fall_next.upd_tgl = ~fall_reg.upd_tgl;
        end
        fall_next.extest = (fall_next.ir_act == INS_EXTEST);
        fall_next.highz  = (fall_next.ir_act == INS_HIGHZ);
        fall_next.in_tlr = (rise_reg.state == ST_TLR);
        // TDO is driven only while a register sits in the path.
        fall_next.tdo_oe = (rise_reg.state == ST_SHIFT_IR) ||
                           (rise_reg.state == ST_SHIFT_DR);
        if (rise_reg.state == ST_SHIFT_IR) begin
            fall_next.tdo = rise_reg.ir_shift[0];
        end else if (rise_reg.state == ST_SHIFT_DR) begin
            unique case (dsel)
                DS_BYPASS: fall_next.tdo = rise_reg.byp;
                DS_ID:     fall_next.tdo = rise_reg.id_shift[0];
                DS_BSR:    fall_next.tdo = rise_reg.bsr.inp[0];
            endcase
        end
    end

    // Register on the falling edge; reset gives the identification code.
    always_ff @(negedge TCK_IN or negedge TRST_N_IN) begin
        if (!TRST_N_IN) begin
            fall_reg        <= '0;
            fall_reg.ir_act <= IR_RESET;
            fall_reg.in_tlr <= 1'b1;
        end else begin
            fall_reg <= fall_next;
        end
    end

    assign TDO_OUT    = fall_reg.tdo;
    assign TDO_OE_OUT = fall_reg.tdo_oe;

    // -------------------------------------------------------------------
    // Device clock: pin multiplexers
    // -------------------------------------------------------------------

    // The boundary word is taken only after the toggle has settled through
    // two stages; by then the update latches have been still for far longer
    // than a device clock, and they cannot move again before the next toggle
    // since a new update needs many test clocks. Bypass and identification
    // never touch these multiplexers.
    always_comb begin
        sys_next = sys_reg;
        sys_next.tgl_seen = s_tgl;
        if (s_tgl != sys_reg.tgl_seen) begin
            sys_next.bsr = fall_reg.bsr_upd;
        end
        if (s_ext) begin
            sys_next.pad_out = sys_reg.bsr.outp;
            sys_next.core_in = sys_reg.bsr.inp;
        end else begin
            sys_next.pad_out = CORE_DATA_IN;
            sys_next.core_in = pad_sys;
        end
        if (s_hz) begin
            sys_next.pad_oe = 1'b0;
        end else if (s_ext) begin
            sys_next.pad_oe = sys_reg.bsr.oe;
        end else begin
            sys_next.pad_oe = CORE_OE_IN;
        end
        // Tells the queue logic that normal operation may begin.
        sys_next.idle = s_tlr;
    end

    // Register the device-clock state.
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sys_reg <= '0;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign PAD_OUT       = sys_reg.pad_out;
    assign PAD_OE_OUT    = sys_reg.pad_oe;
    assign CORE_IN_OUT   = sys_reg.core_in;
    assign TEST_IDLE_OUT = sys_reg.idle;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------

    // Run of consecutive TMS-high edges, saturating at five.
    logic [2:0] tms_run;

    always_ff @(posedge TCK_IN or negedge TRST_N_IN) begin
        if (!TRST_N_IN) begin
            tms_run <= 3'h0;
        end else if (!TMS_IN) begin
            tms_run <= 3'h0;
        end else if (tms_run != 3'h5) begin
            tms_run <= tms_run + 3'h1;
        end
    end

    // Five high edges in a row always land in reset.
    chk_five_ones: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        tms_run == 3'h5 |-> rise_reg.state == ST_TLR)
        else $error("TAP not in reset after five TMS-high edges");

    // Select-DR-Scan branches by TMS.
    chk_sel_branch: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_SEL_DR |=>
        rise_reg.state == ($past(TMS_IN) ? ST_SEL_IR : ST_CAP_DR))
        else $error("Select-DR-Scan took the wrong branch");

    // Capture-IR leaves 01 in the lowest bits.
    chk_ir_capture: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_CAP_IR |=> rise_reg.ir_shift[1:0] == 2'b01)
        else $error("Capture-IR pattern wrong");

    // Shift-IR moves one bit and takes TDI at the top.
    chk_ir_shift: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_SHIFT_IR |=>
        rise_reg.ir_shift == {$past(TDI_IN), $past(rise_reg.ir_shift[3:1])})
        else $error("Shift-IR did not shift one bit");

    // Pause holds every data shift path.
    chk_pause_hold: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_PAUSE_DR |=>
        $stable(rise_reg.id_shift) && $stable(rise_reg.bsr) && $stable(rise_reg.byp))
        else $error("Pause-DR changed a shift path");

    // Bypass stage reads zero after capture.
    chk_byp_clear: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_CAP_DR && dsel == DS_BYPASS |=> !rise_reg.byp)
        else $error("Bypass stage not cleared in Capture-DR");

    // Identification capture loads the fixed code.
    chk_id_capture: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_CAP_DR && dsel == DS_ID |=>
        rise_reg.id_shift == IDCODE_VAL && rise_reg.id_shift[0])
        else $error("Identification capture wrong");

    // Update-IR latches the shifted instruction on the falling edge.
    chk_ir_update: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_UPD_IR |=> fall_reg.ir_act == $past(rise_reg.ir_shift))
        else $error("Update-IR did not latch the instruction");

    // Reset state restores the identification instruction and normal pins.
    chk_tlr_idle: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_TLR |=>
        fall_reg.ir_act == INS_IDCODE && !fall_reg.extest && !fall_reg.highz)
        else $error("Reset state left test logic active");

    // High-impedance mode floats the outputs on the next device clock.
    chk_highz_off: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        s_hz |=> !PAD_OE_OUT)
        else $error("Outputs driven under high-impedance instruction");

    // Pause-IR holds the instruction stages still.
    chk_pause_ir: assert property (
        @(posedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_PAUSE_IR |=> $stable(rise_reg.ir_shift))
        else $error("Pause-IR changed the instruction stages");

    // A shift state drives the serial output on the following falling edge.
    chk_tdo_drive: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state inside {ST_SHIFT_IR, ST_SHIFT_DR} |=> TDO_OE_OUT)
        else $error("Serial output not driven in a shift state");

    // Outside the shift states the serial output is released.
    chk_tdo_quiet: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        !(rise_reg.state inside {ST_SHIFT_IR, ST_SHIFT_DR}) |=> !TDO_OE_OUT)
        else $error("Serial output driven outside a shift state");

    // Shift-IR shows the stage nearest the output first.
    chk_ir_lsb: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_SHIFT_IR |=> TDO_OUT == $past(rise_reg.ir_shift[0]))
        else $error("Shift-IR did not show the lowest stage");

    // The bypass stage alone forms the path when selected.
    chk_byp_path: assert property (
        @(negedge TCK_IN) disable iff (!TRST_N_IN)
        rise_reg.state == ST_SHIFT_DR && dsel == DS_BYPASS |=>
        TDO_OUT == $past(rise_reg.byp))
        else $error("Bypass stage not in the serial path");

    // While test reset is held the controller sits in reset; checked at release.
    chk_trst_force: assert property (
        @(posedge TRST_N_IN)
        rise_reg.state == ST_TLR && fall_reg.ir_act == IR_RESET && !TDO_OE_OUT)
        else $error("Test reset did not force the reset state");

    // External test drives pins and core inputs from the update cells.
    chk_ext_pins: assert property (
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        s_ext |=> PAD_OUT == $past(sys_reg.bsr.outp) &&
        CORE_IN_OUT == $past(sys_reg.bsr.inp))
        else $error("External test pins do not follow the update cells");

endmodule // jtb_tap

`default_nettype wire

// file: bench/jtb_tester.sv
// Board tester model: drives the test clock, mode select and serial input.
`timescale 1ns/1ns
`default_nettype none

module jtb_tester (
    output logic      tck_out,  // Test clock, still low between steps.
    output logic      tms_out,  // Mode select.
    output logic      tdi_out,  // Serial data to the device.
    input  wire logic tdo_in    // Serial data from the device.
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // One 6 ns clock cycle with a 3 ns high pulse; TDO is taken just before the rising edge.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        #3 tdo = tdo_in;
        tck_out = 1'b1;
        #3 tck_out = 1'b0;
    endtask

    // Five mode-select-high pulses put the port in reset from any state.
    task automatic tap_reset();
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
    endtask
endmodule : jtb_tester

`default_nettype wire

// file: bench/jtb_tap_tb_top.sv
// Self-checking bench of the boundary-scan test access port.
`timescale 1ns/1ns
`default_nettype none

module jtb_tap_tb_top;
    import jtb_pkg::*;
    logic clk = 0, rst_n = 1, trst_n = 1, core_oe = 1;
    logic tck, tms, tdi, tdo, tdo_oe, pad_oe, idle;
    logic [PIN_W-1:0] pad_in = 4'hA, core_dat = 4'h5, pad_out, core_in;
    logic [31:0] d;
    int num_errors = 0, num_checks = 0;
    int pause_at = -1;  // Shift bit after which a scan pauses, none if negative.
    always #50 clk = ~clk;

    jtb_tap jtb_tap_i (.CLK_IN(clk), .RST_N_IN(rst_n), .TCK_IN(tck),
        .TRST_N_IN(trst_n), .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo),
        .TDO_OE_OUT(tdo_oe), .PAD_IN(pad_in), .PAD_OUT(pad_out),
        .PAD_OE_OUT(pad_oe), .CORE_DATA_IN(core_dat), .CORE_OE_IN(core_oe),
        .CORE_IN_OUT(core_in), .TEST_IDLE_OUT(idle));
    jtb_tester jtb_tester_i (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo_oe ? tdo : ~tdo));

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for the synchronised reset flag.
    task automatic wait_idle(input logic e);
        for (int k = 0; k < 8 && idle !== e; k++) @(posedge clk);
        chk(idle, e);
        if (idle !== e) give_verdict();
    endtask

    // Full scan from Run-Test-Idle back to Run-Test-Idle, LSB first.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic b;
        dout = '0;
        jtb_tester_i.step(1, 0, b);
        if (ir) jtb_tester_i.step(1, 0, b);
        jtb_tester_i.step(0, 0, b);
        jtb_tester_i.step(0, 0, b);
        for (int i = 0; i < n; i++) begin
            jtb_tester_i.step(i == n - 1 || i == pause_at, din[i], b);
            dout[i] = b;
            // Exit1, Pause twice, Exit2, then back to Shift with contents kept.
            if (i == pause_at && i != n - 1) begin
                jtb_tester_i.step(0, 0, b);
                jtb_tester_i.step(0, 0, b);
                jtb_tester_i.step(1, 0, b);
                jtb_tester_i.step(0, 0, b);
            end
        end
        jtb_tester_i.step(1, 0, b);
        jtb_tester_i.step(0, 0, b);
    endtask

    // Bypass-style codes give a one-stage path that reads zero first.
    task automatic t_bypass(input logic [3:0] code);
        scan(1, 4, {28'h0, code}, d);
        chk(d[3:0], IR_CAPTURE);
        scan(0, 2, 32'h3, d);
        chk(d[1:0], 2'b10);
        chk(pad_out, core_dat);
    endtask

    initial begin
        logic b;
        @(posedge clk);
        rst_n <= 0;
        trst_n <= 0;
        repeat (3) @(posedge clk);
        trst_n <= 1;
        rst_n <= 1;
        wait_idle(1);
        jtb_tester_i.step(0, 0, b);
        wait_idle(0);
        scan(0, 32, 32'h0, d);
        chk(d, IDCODE_VAL);
        pause_at = 5;
        scan(0, 32, 32'h0, d);
        chk(d, IDCODE_VAL);
        pause_at = 1;
        t_bypass(4'h3);
        pause_at = -1;
        t_bypass(INS_BYPASS);
        t_bypass(INS_HIGHZ);
        repeat (6) @(posedge clk);
        chk(pad_oe, 1'b0);
        scan(1, 4, {28'h0, INS_SAMPLE}, d);
        chk(pad_out, core_dat);
        scan(0, 9, 32'h169, d);
        chk(d[3:0], pad_in);
        scan(1, 4, {28'h0, INS_EXTEST}, d);
        repeat (8) @(posedge clk);
        chk({pad_oe, pad_out, core_in}, 9'h169);
        jtb_tester_i.tap_reset();
        wait_idle(1);
        repeat (4) @(posedge clk);
        chk(pad_out, core_dat);
        jtb_tester_i.step(0, 0, b);
        scan(0, 32, 32'h0, d);
        chk(d, IDCODE_VAL);
        t_bypass(INS_BYPASS);
        @(posedge clk);
        trst_n <= 0;
        repeat (2) @(posedge clk);
        trst_n <= 1;
        wait_idle(1);
        jtb_tester_i.step(0, 0, b);
        scan(0, 32, 32'h0, d);
        chk(d, IDCODE_VAL);
        give_verdict();
    end
endmodule : jtb_tap_tb_top

`default_nettype wire
